// ==== hdl/pgr_defs.vh ====
// constants for the pll programming register block: offsets, fields, reset values
`ifndef PGR_DEFS_VH
`define PGR_DEFS_VH

// ==================================================
// register offsets (word index on the plain register port)
`define PGR_ADDR_W 3
`define PGR_OFF_CONTROL 3'h0
`define PGR_OFF_BANDWIDTH 3'h1
`define PGR_OFF_MULT_HIGH 3'h2
`define PGR_OFF_MULT_LOW 3'h3
`define PGR_OFF_VCO_RANGE 3'h4
`define PGR_OFF_REF_DIV 3'h5

// ==================================================
// pll_control field positions
`define PGR_CTL_IRQ_EN 7
`define PGR_CTL_FLAG 6
`define PGR_CTL_POWER 5
`define PGR_CTL_BCS 4
`define PGR_CTL_PRE_HI 3
`define PGR_CTL_PRE_LO 2
`define PGR_CTL_VPR_HI 1
`define PGR_CTL_VPR_LO 0

// ==================================================
// pll_bandwidth_control field positions
`define PGR_BWC_AUTO 7
`define PGR_BWC_LOCK 6
`define PGR_BWC_ACQ_N 5

// ==================================================
// reset values
`define PGR_RST_POWER 1'b1
`define PGR_RST_PRE 2'h0
`define PGR_RST_VPR 2'h0
`define PGR_RST_MULT 12'h0_040
`define PGR_RST_VRS 8'h40
`define PGR_RST_RDS 4'h1
`define PGR_RST_BYTE 8'h00

`endif

// ==== hdl/pgr_lock_watch.v ====
// lock status register and lock-change event detector
`timescale 1ns/1ps
`default_nettype none

module pgr_lock_watch (
  input wire ref_clk,
  input wire resetn,
  input wire lockIn,
  input wire autoMode,
  output reg lockState,
  output reg lockChange
);

  // ==================================================
  // follow the detector and pulse on every change in automatic mode
  always @(posedge ref_clk) begin
    if (!resetn) begin
      lockState <= 1'b0;
      lockChange <= 1'b0;
    end else begin
      lockState <= lockIn;
      lockChange <= autoMode & (lockIn ^ lockState);
    end
  end

endmodule // pgr_lock_watch

`default_nettype wire

// ==== hdl/pgr_pll_regs.v ====
// pll programming registers: control, bandwidth, multiplier, range and divider
//
// Behaviour
// - prescaler field codes 00/01/10 give 1/2/4; locked while powered; reset clears.
// - vco power range codes 00..11 give 1/2/4/8; locked while powered; reset clears.
// - bandwidth mode bit: 1 automatic, 0 manual; reset gives manual.
// - lock bit read-only, set when locked in automatic mode; reads 0 in manual.
// - acquisition bit status in automatic, writable in manual; 1 tracking; reset 0.
// - manual acquisition value is kept during automatic mode and restored after.
// - twelve-bit feedback multiplier resets to 64 and is locked while powered.
// - feedback multiplier zero acts exactly like one.
// - upper nibbles of multiplier high and reference divider read zero.
// - vco range linear multiplier resets to 64 and is locked while powered.
// - vco range zero disables the pll and forces base clock select clear.
// - reference divider resets to 1, zero acts as 1, locked while powered.
// - each lock change in automatic mode sets the flag; irq also needs enable.
// - manual mode raises no interrupt and the lock-change flag reads 0.
// - base clock select may be set while unlocked; software checks lock first.
// - a read of pll_control clears the lock-change flag; a lock change in the same cycle wins.
// - select needs power on; power cannot be cleared while select is set.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pgr_defs.vh"

module pgr_pll_regs (
  input wire ref_clk,
  input wire resetn,
  // plain register port
  input wire [`PGR_ADDR_W-1:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regReadData,
  // from the analog loop and lock detector
  input wire lockDetect,
  input wire trackingStatus,
  // to the analog loop and base clock selector
  output reg synthPowerOn,
  output reg baseClockSelect,
  output reg [1:0] prescalerSelect,
  output reg [1:0] vcoPowerRange,
  output reg [11:0] feedbackMultiplier,
  output reg [7:0] vcoRangeLinear,
  output reg [3:0] referenceDivide,
  output reg autoBandwidth,
  output reg acquisitionModeN,
  output reg lockChangeIrq
);

  // ==================================================
  // helpers

  // a divide or multiply value of zero behaves as one
  function [11:0] atLeastOne;
    input [11:0] value;
    begin
      if (value == 12'h0_000) begin
        atLeastOne = 12'h0_001;
      end else begin
        atLeastOne = value;
      end
    end
  endfunction

  // ==================================================
  // stored register state

  reg ctlIrqEnable;
  reg ctlFlag;
  reg ctlPower;
  reg ctlBcs;
  reg [1:0] ctlPrescaler;
  reg [1:0] ctlPowerRange;
  reg bwcAuto;
  reg bwcAcqShadow;
  reg [11:0] multValue;
  reg [7:0] vrsValue;
  reg [3:0] rdsValue;
  reg trackingSeen;

  // ==================================================
  // lock status tracking

  wire lockState;
  wire lockChange;

  // lock follows the detector every cycle; events count only in automatic mode
  pgr_lock_watch i_pgr_lock_watch (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .lockIn(lockDetect),
    .autoMode(bwcAuto),
    .lockState(lockState),
    .lockChange(lockChange)
  );

  // ==================================================
  // access decode

  // one decode per register; unmapped offsets hit nothing
  wire writeControl = regWrite & (regAddr == `PGR_OFF_CONTROL);
  wire writeBandwidth = regWrite & (regAddr == `PGR_OFF_BANDWIDTH);
  wire writeMultHigh = regWrite & (regAddr == `PGR_OFF_MULT_HIGH);
  wire writeMultLow = regWrite & (regAddr == `PGR_OFF_MULT_LOW);
  wire writeVcoRange = regWrite & (regAddr == `PGR_OFF_VCO_RANGE);
  wire writeRefDiv = regWrite & (regAddr == `PGR_OFF_REF_DIV);
  wire readControl = regRead & (regAddr == `PGR_OFF_CONTROL);

  // programming fields accept writes only while the pll is off
  wire progOpen = ~ctlPower;

  // a zero range value holds the pll off and the select clear
  wire rangeZero = (vrsValue == 8'h00);

  // ==================================================
  // effective values and status views

  // zero multiplier or divider values act as one at the loop
  wire [11:0] multEffective = atLeastOne(multValue);
  wire [11:0] rdsEffective = atLeastOne({8'h00, rdsValue});

  // status bits read as zero in manual mode
  wire flagView = ctlFlag & bwcAuto;
  wire lockView = lockState & bwcAuto;

  // manual mode shows the written value; automatic shows the loop state
  wire acqView = bwcAuto ? trackingSeen : bwcAcqShadow;

  // ==================================================
  // next values for the control register

  reg next_ctlPower;
  reg next_ctlBcs;
  reg next_ctlIrqEnable;

  // power and select interlock; select needs the power already on
  always @* begin
    next_ctlPower = ctlPower;
    next_ctlBcs = ctlBcs;
    next_ctlIrqEnable = ctlIrqEnable;
    if (writeControl) begin
      // select only sets when the pll is already on; lock is not checked
      next_ctlBcs = regWriteData[`PGR_CTL_BCS] & ctlPower & ~rangeZero;
      // power stays set while the vco drives the base clock or takes it now,
      // so the select can never stand with the pll off
      if (!ctlBcs && !next_ctlBcs) begin
        next_ctlPower = regWriteData[`PGR_CTL_POWER];
      end
      next_ctlIrqEnable = regWriteData[`PGR_CTL_IRQ_EN];
    end
    // a zero range forces the select clear
    if (rangeZero) begin
      next_ctlBcs = 1'b0;
    end
    // manual bandwidth forces the enable clear
    if (!bwcAuto) begin
      next_ctlIrqEnable = 1'b0;
    end
  end

  // ==================================================
  // control register

  always @(posedge ref_clk) begin
    if (!resetn) begin
      ctlPower <= `PGR_RST_POWER;
      ctlBcs <= 1'b0;
      ctlIrqEnable <= 1'b0;
      ctlPrescaler <= `PGR_RST_PRE;
      ctlPowerRange <= `PGR_RST_VPR;
    end else begin
      ctlPower <= next_ctlPower;
      ctlBcs <= next_ctlBcs;
      ctlIrqEnable <= next_ctlIrqEnable;
      if (writeControl && progOpen) begin
        ctlPrescaler <= regWriteData[`PGR_CTL_PRE_HI:`PGR_CTL_PRE_LO];
        ctlPowerRange <= regWriteData[`PGR_CTL_VPR_HI:`PGR_CTL_VPR_LO];
      end
    end
  end

  // ==================================================
  // lock-change flag: a change in the read cycle wins over the clear

  always @(posedge ref_clk) begin
    if (!resetn) begin
      ctlFlag <= 1'b0;
    end else if (!bwcAuto) begin
      // held clear so no stale event fires on return to automatic
      ctlFlag <= 1'b0;
    end else if (lockChange) begin
      ctlFlag <= 1'b1;
    end else if (readControl) begin
      ctlFlag <= 1'b0;
    end
  end

  // ==================================================
  // bandwidth control register

  // the acquisition value written in manual mode sits untouched in automatic
  always @(posedge ref_clk) begin
    if (!resetn) begin
      bwcAuto <= 1'b0;
      bwcAcqShadow <= 1'b0;
    end else begin
      if (writeBandwidth) begin
        bwcAuto <= regWriteData[`PGR_BWC_AUTO];
      end
      // the lock bit position is not stored; a written one is dropped
      if (writeBandwidth && !bwcAuto) begin
        bwcAcqShadow <= regWriteData[`PGR_BWC_ACQ_N];
      end
    end
  end

  // loop acquisition status, sampled for reads in automatic mode
  always @(posedge ref_clk) begin
    if (!resetn) begin
      trackingSeen <= 1'b0;
    end else begin
      trackingSeen <= trackingStatus;
    end
  end

  // ==================================================
  // multiplier, range and divider registers

  always @(posedge ref_clk) begin
    if (!resetn) begin
      multValue <= `PGR_RST_MULT;
      vrsValue <= `PGR_RST_VRS;
      rdsValue <= `PGR_RST_RDS;
    end else if (progOpen) begin
      if (writeMultHigh) begin
        multValue[11:8] <= regWriteData[3:0];
      end
      if (writeMultLow) begin
        multValue[7:0] <= regWriteData;
      end
      if (writeVcoRange) begin
        vrsValue <= regWriteData;
      end
      if (writeRefDiv) begin
        rdsValue <= regWriteData[3:0];
      end
    end
  end

  // ==================================================
  // read data mux

  reg [7:0] next_readData;

  // unmapped offsets and reserved bits read as zero
  always @* begin
    next_readData = `PGR_RST_BYTE;
    case (regAddr)
      `PGR_OFF_CONTROL: begin
        next_readData[`PGR_CTL_IRQ_EN] = ctlIrqEnable;
        next_readData[`PGR_CTL_FLAG] = flagView;
        next_readData[`PGR_CTL_POWER] = ctlPower;
        next_readData[`PGR_CTL_BCS] = ctlBcs;
        next_readData[`PGR_CTL_PRE_HI:`PGR_CTL_PRE_LO] = ctlPrescaler;
        next_readData[`PGR_CTL_VPR_HI:`PGR_CTL_VPR_LO] = ctlPowerRange;
      end
      `PGR_OFF_BANDWIDTH: begin
        next_readData[`PGR_BWC_AUTO] = bwcAuto;
        next_readData[`PGR_BWC_LOCK] = lockView;
        if (bwcAuto) begin
          next_readData[`PGR_BWC_ACQ_N] = trackingSeen;
        end else begin
          next_readData[`PGR_BWC_ACQ_N] = bwcAcqShadow;
        end
      end
      `PGR_OFF_MULT_HIGH: begin
        next_readData[3:0] = multValue[11:8];
      end
      `PGR_OFF_MULT_LOW: begin
        next_readData = multValue[7:0];
      end
      `PGR_OFF_VCO_RANGE: begin
        next_readData = vrsValue;
      end
      `PGR_OFF_REF_DIV: begin
        next_readData[3:0] = rdsValue;
      end
      default: begin
        next_readData = `PGR_RST_BYTE;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (!resetn) begin
      regReadData <= `PGR_RST_BYTE;
    end else if (regRead) begin
      regReadData <= next_readData;
    end else begin
      regReadData <= `PGR_RST_BYTE;
    end
  end

  // ==================================================
  // registered outputs to the loop and clock selector

  always @(posedge ref_clk) begin
    if (!resetn) begin
      synthPowerOn <= 1'b0;
      baseClockSelect <= 1'b0;
      prescalerSelect <= `PGR_RST_PRE;
      vcoPowerRange <= `PGR_RST_VPR;
      feedbackMultiplier <= `PGR_RST_MULT;
      vcoRangeLinear <= `PGR_RST_VRS;
      referenceDivide <= `PGR_RST_RDS;
      autoBandwidth <= 1'b0;
      acquisitionModeN <= 1'b0;
      lockChangeIrq <= 1'b0;
    end else begin
      // the pll runs only with a nonzero range value
      synthPowerOn <= ctlPower & ~rangeZero;
      baseClockSelect <= ctlBcs & ~rangeZero;
      // loop settings follow the stored fields one cycle later
      prescalerSelect <= ctlPrescaler;
      vcoPowerRange <= ctlPowerRange;
      feedbackMultiplier <= multEffective;
      vcoRangeLinear <= vrsValue;
      referenceDivide <= rdsEffective[3:0];
      autoBandwidth <= bwcAuto;
      // manual mode drives the written value; automatic leaves it to the loop
      acquisitionModeN <= acqView;
      // interrupt needs automatic mode, the flag and the enable
      lockChangeIrq <= flagView & ctlIrqEnable;
    end
  end

endmodule // pgr_pll_regs

`default_nettype wire

// ==== verification/pgr_pll_regs_props.sv ====
// port-level assertions for the pll programming registers
`timescale 1ns/1ps
`default_nettype none
`include "pgr_defs.vh"
// ==================================================
// checker module
module pgr_pll_regs_props (
  input wire ref_clk,
  input wire resetn,
  input wire [`PGR_ADDR_W-1:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regReadData,
  input wire lockDetect,
  input wire trackingStatus,
  input wire synthPowerOn,
  input wire baseClockSelect,
  input wire [1:0] prescalerSelect,
  input wire [1:0] vcoPowerRange,
  input wire [11:0] feedbackMultiplier,
  input wire [7:0] vcoRangeLinear,
  input wire [3:0] referenceDivide,
  input wire autoBandwidth,
  input wire acquisitionModeN,
  input wire lockChangeIrq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // read cycles of interest
  sequence s_rdRange;
    regRead && regAddr == `PGR_OFF_VCO_RANGE;
  endsequence
  sequence s_rdHigh;
    regRead && (regAddr == `PGR_OFF_MULT_HIGH || regAddr == `PGR_OFF_REF_DIV);
  endsequence
  sequence s_rdBw;
    regRead && regAddr == `PGR_OFF_BANDWIDTH;
  endsequence
  // read data one cycle later, against the pins or reserved zeros
  property p_rangeRead;
    s_rdRange |=> regReadData == vcoRangeLinear;
  endproperty
  a_rangeRead: assert property (p_rangeRead) else $error("range read differs");
  property p_upperZero;
    s_rdHigh |=> regReadData[7:4] == 4'h0;
  endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper nibble set");
  property p_manualBw;
    s_rdBw |=> (!autoBandwidth |-> !regReadData[6] && regReadData[5] == acquisitionModeN);
  endproperty
  a_manualBw: assert property (p_manualBw) else $error("manual status wrong");
  // settings frozen while the synthesiser is powered
  property p_protect;
    $past(synthPowerOn) |-> $stable({prescalerSelect, vcoPowerRange, feedbackMultiplier,
      vcoRangeLinear, referenceDivide});
  endproperty
  a_protect: assert property (p_protect) else $error("field moved while on");
  property p_nonZero;
    feedbackMultiplier != 12'h000 && referenceDivide != 4'h0;
  endproperty
  a_nonZero: assert property (p_nonZero) else $error("zero divider shown");
  // base clock select guards and the manual-mode interrupt check
  property p_selPower;
    baseClockSelect |-> synthPowerOn;
  endproperty
  a_selPower: assert property (p_selPower) else $error("select without power");
  property p_selRange;
    baseClockSelect |-> vcoRangeLinear != 8'h00;
  endproperty
  a_selRange: assert property (p_selRange) else $error("select with range zero");
  property p_noIrqManual;
    !autoBandwidth && !$past(autoBandwidth) |-> !lockChangeIrq;
  endproperty
  a_noIrqManual: assert property (p_noIrqManual) else $error("irq in manual");
endmodule // pgr_pll_regs_props

bind pgr_pll_regs pgr_pll_regs_props i_pgr_pll_regs_props (.ref_clk, .resetn, .regAddr,
  .regWriteData, .regWrite, .regRead, .regReadData, .lockDetect, .trackingStatus,
  .synthPowerOn, .baseClockSelect, .prescalerSelect, .vcoPowerRange, .feedbackMultiplier,
  .vcoRangeLinear, .referenceDivide, .autoBandwidth, .acquisitionModeN, .lockChangeIrq);
`default_nettype wire

// ==== verification/pgr_pll_regs_test.sv ====
// self-checking bench for the pll programming registers
`timescale 1ns/1ps
`default_nettype none
`include "pgr_defs.vh"
// ==================================================
// bench top
module pgr_pll_regs_test;
  logic ref_clk, resetn, regWrite, regRead, lockDetect, trackingStatus;
  logic [2:0] regAddr;
  logic [7:0] regWriteData, regReadData, vcoRangeLinear, d;
  logic [1:0] prescalerSelect, vcoPowerRange;
  logic [11:0] feedbackMultiplier;
  logic [3:0] referenceDivide;
  logic synthPowerOn, baseClockSelect, autoBandwidth, acquisitionModeN, lockChangeIrq;
  integer seed = 32'hd1d8_82ea;
  integer miscompares = 0;
  integer cmp_count = 0;
  integer i;
  pgr_pll_regs i_pgr_pll_regs (.ref_clk, .resetn, .regAddr, .regWriteData, .regWrite,
    .regRead, .regReadData, .lockDetect, .trackingStatus, .synthPowerOn, .baseClockSelect,
    .prescalerSelect, .vcoPowerRange, .feedbackMultiplier, .vcoRangeLinear,
    .referenceDivide, .autoBandwidth, .acquisitionModeN, .lockChangeIrq);
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // expected helpers: zero divider acts as one, control byte assembly
  function automatic logic [11:0] effOne(input logic [11:0] v);
    return (v == 12'h000) ? 12'h001 : v;
  endfunction
  function automatic logic [7:0] ctl(input logic [3:0] hi, input logic [1:0] pr, vp);
    return {hi, pr, vp};
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write and read on the register port
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= v;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regReadData, exp);
  endtask
  // let written values reach the output pins
  task automatic pins;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic lockTo(input logic v);
    @(posedge ref_clk);
    lockDetect <= v;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog: whole run needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    end_of_test;
  end
  // main sequence
  initial begin
    {regWrite, regRead, lockDetect, trackingStatus, resetn} = 5'h00;
    regAddr = 3'h0;
    regWriteData = 8'h00;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`PGR_OFF_CONTROL, ctl(4'h2, 2'h0, 2'h0));
    rd(`PGR_OFF_BANDWIDTH, 8'h00);
    rd(`PGR_OFF_MULT_HIGH, 8'h00);
    rd(3'h7, 8'h00);
    $display("reset test done");
    // random writes while powered must be dropped
    for (i = 0; i < 9; i++) begin
      d = $random(seed);
      wr(3'(3 + i % 3), d);
    end
    wr(`PGR_OFF_CONTROL, 8'h2a);
    rd(`PGR_OFF_MULT_LOW, 8'h40);
    rd(`PGR_OFF_VCO_RANGE, 8'h40);
    rd(`PGR_OFF_REF_DIV, 8'h01);
    rd(`PGR_OFF_CONTROL, 8'h20);
    $display("protection test done");
    // codes with power off; range code 3 is never programmed
    for (i = 0; i < 3; i++) begin
      wr(`PGR_OFF_CONTROL, ctl(4'h0, 2'(i), 2'(i)));
      pins;
      chk({prescalerSelect, vcoPowerRange}, {2'(i), 2'(i)});
      chk(synthPowerOn, 1'b0);
    end
    d = $random(seed);
    wr(`PGR_OFF_MULT_HIGH, 8'hff);
    wr(`PGR_OFF_MULT_LOW, d);
    pins;
    chk(feedbackMultiplier, {4'hf, d});
    rd(`PGR_OFF_MULT_HIGH, 8'h0f);
    wr(`PGR_OFF_MULT_HIGH, 8'h00);
    wr(`PGR_OFF_MULT_LOW, 8'h00);
    wr(`PGR_OFF_REF_DIV, 8'hf0);
    pins;
    chk(feedbackMultiplier, effOne(12'h000));
    chk(referenceDivide, effOne(12'h000));
    rd(`PGR_OFF_REF_DIV, 8'h00);
    $display("field test done");
    // range zero blocks select; select allowed while unlocked
    wr(`PGR_OFF_VCO_RANGE, 8'h00);
    wr(`PGR_OFF_BANDWIDTH, 8'h00);
    wr(`PGR_OFF_CONTROL, 8'h20);
    wr(`PGR_OFF_CONTROL, 8'h30);
    pins;
    chk({baseClockSelect, synthPowerOn}, 2'b00);
    wr(`PGR_OFF_CONTROL, 8'h00);
    wr(`PGR_OFF_VCO_RANGE, 8'h40);
    wr(`PGR_OFF_CONTROL, 8'h30);
    pins;
    chk(baseClockSelect, 1'b0);
    wr(`PGR_OFF_CONTROL, 8'h10);
    wr(`PGR_OFF_CONTROL, 8'h10);
    pins;
    chk(baseClockSelect, 1'b1);
    chk({vcoRangeLinear, synthPowerOn}, {8'h40, 1'b1});
    rd(`PGR_OFF_CONTROL, 8'h30);
    $display("select test done");
    // acquisition bit: manual write, auto status, restore
    wr(`PGR_OFF_BANDWIDTH, 8'h20);
    rd(`PGR_OFF_BANDWIDTH, 8'h20);
    wr(`PGR_OFF_BANDWIDTH, 8'ha0);
    pins;
    rd(`PGR_OFF_BANDWIDTH, 8'h80);
    @(posedge ref_clk);
    trackingStatus <= 1'b1;
    pins;
    rd(`PGR_OFF_BANDWIDTH, 8'ha0);
    chk({autoBandwidth, acquisitionModeN}, 2'b11);
    @(posedge ref_clk);
    trackingStatus <= 1'b0;
    wr(`PGR_OFF_BANDWIDTH, 8'h00);
    rd(`PGR_OFF_BANDWIDTH, 8'h20);
    chk({autoBandwidth, acquisitionModeN}, 2'b01);
    $display("bandwidth test done");
    // lock events in auto, then in manual
    wr(`PGR_OFF_BANDWIDTH, 8'ha0);
    wr(`PGR_OFF_CONTROL, 8'hb0);
    lockTo(1'b1);
    chk(lockChangeIrq, 1'b1);
    rd(`PGR_OFF_BANDWIDTH, 8'hc0);
    rd(`PGR_OFF_CONTROL, 8'hf0);
    rd(`PGR_OFF_CONTROL, 8'hb0);
    chk(lockChangeIrq, 1'b0);
    wr(`PGR_OFF_CONTROL, 8'h30);
    lockTo(1'b0);
    chk(lockChangeIrq, 1'b0);
    rd(`PGR_OFF_CONTROL, 8'h70);
    wr(`PGR_OFF_BANDWIDTH, 8'h00);
    lockTo(1'b1);
    chk(lockChangeIrq, 1'b0);
    rd(`PGR_OFF_CONTROL, 8'h30);
    rd(`PGR_OFF_BANDWIDTH, 8'h20);
    $display("lock event test done");
    end_of_test;
  end
endmodule // pgr_pll_regs_test
`default_nettype wire
